// >>> design/seerd_regs.svh
`ifndef SEERD_REGS_SVH
`define SEERD_REGS_SVH

// Device type code; value is arbitrary
`define SEERD_DEV_TYPE   4'h5
`define SEERD_BITS       4'h8
`define SEERD_LAST_BIT   4'h7
`define SEERD_PAGE_MASK  8'hfc
`define SEERD_PAGE_STEP  2'h1
`define SEERD_PTR_STEP   8'h01
`define SEERD_CLK_HZ     20000000
`define SEERD_TWR_MS     5
`define SEERD_WR_CYCLES  ((`SEERD_TWR_MS * `SEERD_CLK_HZ) / 1000)
`define SEERD_BUSY_W     18
`define SEERD_FIFO_DEPTH 8

`endif

// >>> design/seerd_pkg.sv
package seerd_pkg;
    // Gray along idle, address, ack, transmit, master ack
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_DEVADR = 3'h1,
        ST_ACK    = 3'h3,
        ST_TX     = 3'h2,
        ST_RACK   = 3'h6,
        ST_WADR   = 3'h7,
        ST_WDATA  = 3'h5,
        ST_WAIT   = 3'h4
    } seerd_state_t;
endpackage

// >>> design/seerd_fifo.sv
`timescale 1ns/1ps
module seerd_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         flush,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  wp_nxt;
    logic [AW:0]  rp_r;
    logic [AW:0]  rp_nxt;
    logic         push;
    logic         pop;

    assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem_r[rp_r[AW-1:0]];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

// >>> design/seerd_top.sv
// Operation
// - A read opens like a write, start then slave address, with the last address bit set to one.
// - The word pointer holds the last read location plus one; after a write it holds the next location in the four-byte page.
// - A current-address read is acknowledged and the addressed byte goes out over eight clocks.
// - A random read is a dummy write of the word address, repeated start, then a read address.
// - Each byte the master acknowledges is followed by the next byte.
// - The read pointer steps through all eight bits and wraps from 255 to 0.
// - After eight data bits the line is released; no acknowledge means wait for stop.
// - Only a slave address whose four-bit type field matches is acknowledged.
// - In a write transfer the next byte is loaded into the pointer and acknowledged.
// - While an internal write is running the slave address is not acknowledged.
`timescale 1ns/1ps
`include "seerd_regs.svh"
module seerd_top #(
    parameter int WR_CYCLES = `SEERD_WR_CYCLES
) (
    // System
    input  wire logic sys_clk,
    input  wire logic rst,
    // Two-wire bus
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    output logic      sda_val,
    output logic      sda_oe,
    // Status
    output logic      wr_busy
);
    logic [7:0] mem_r [256];

    logic [2:0] scl_r;
    logic [2:0] sda_r;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;

    seerd_pkg::seerd_state_t st_r, st_nxt, after_r, after_nxt;
    logic [3:0]                 cnt_r, cnt_nxt;
    logic [7:0]                 sh_r, sh_nxt;
    logic [7:0]                 tx_r, tx_nxt;
    logic [7:0]                 ptr_r, ptr_nxt;
    logic [7:0]                 pf_r, pf_nxt;
    logic                       oe_r, oe_nxt;
    logic                       wrote_r, wrote_nxt;
    logic [`SEERD_BUSY_W-1:0]   busy_r, busy_nxt;
    logic                       flush;
    logic                       pop;
    logic                       mem_we;
    logic                       pf_ready;
    logic                       f_valid;
    logic [7:0]                 f_data;

    // Second stage feeds logic; third is history for edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end else begin
            scl_r <= {scl_r[1:0], scl_pin};
            sda_r <= {sda_r[1:0], sda_pin};
        end
    end

    assign rise  = scl_r[1] && !scl_r[2];
    assign fall  = !scl_r[1] && scl_r[2];
    assign start = scl_r[1] && scl_r[2] && !sda_r[1] && sda_r[2];
    assign stop  = scl_r[1] && scl_r[2] && sda_r[1] && !sda_r[2];

    function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
        shift_in = {v[6:0], b};
    endfunction

    function automatic logic f_push_ok();
        f_push_ok = pf_ready;
    endfunction

    always_comb begin
        st_nxt    = st_r;
        after_nxt = after_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        tx_nxt    = tx_r;
        ptr_nxt   = ptr_r;
        wrote_nxt = wrote_r;
        busy_nxt  = (busy_r != '0) ? busy_r - 1'b1 : busy_r;
        flush     = 1'b0;
        pop       = 1'b0;
        mem_we    = 1'b0;
        if (start) begin
            st_nxt  = seerd_pkg::ST_DEVADR;
            cnt_nxt = '0;
            flush   = 1'b1;
        end else if (stop) begin
            st_nxt = seerd_pkg::ST_IDLE;
            if (wrote_r) begin
                busy_nxt  = `SEERD_BUSY_W'(WR_CYCLES);
                wrote_nxt = 1'b0;
            end
        end else begin
            case (st_r)
                seerd_pkg::ST_DEVADR, seerd_pkg::ST_WADR, seerd_pkg::ST_WDATA: begin
                    if (rise && cnt_r != `SEERD_BITS) begin
                        sh_nxt  = shift_in(sh_r, sda_r[1]);
                        cnt_nxt = cnt_r + 1'b1;
                    end else if (fall && cnt_r == `SEERD_BITS) begin
                        cnt_nxt = '0;
                        st_nxt  = seerd_pkg::ST_ACK;
                        if (st_r == seerd_pkg::ST_DEVADR) begin
                            // Busy write or foreign type: stay silent
                            if (sh_r[7:4] != `SEERD_DEV_TYPE || busy_r != '0) begin
                                st_nxt = seerd_pkg::ST_WAIT;
                            end
                            after_nxt = sh_r[0] ? seerd_pkg::ST_TX
                                                : seerd_pkg::ST_WADR;
                        end else if (st_r == seerd_pkg::ST_WADR) begin
                            ptr_nxt   = sh_r;
                            flush     = 1'b1;
                            after_nxt = seerd_pkg::ST_WDATA;
                        end else begin
                            mem_we    = 1'b1;
                            // Page write wraps inside four bytes
                            ptr_nxt   = (ptr_r & `SEERD_PAGE_MASK)
                                      | {6'h00, ptr_r[1:0] + `SEERD_PAGE_STEP};
                            wrote_nxt = 1'b1;
                            flush     = 1'b1;
                            after_nxt = seerd_pkg::ST_WDATA;
                        end
                    end
                end
                seerd_pkg::ST_ACK: begin
                    if (fall) begin
                        st_nxt = after_r;
                        if (after_r == seerd_pkg::ST_TX) begin
                            // Empty FIFO reads as idle-high bus
                            tx_nxt  = f_valid ? f_data : 8'hff;
                            pop     = 1'b1;
                            ptr_nxt = ptr_r + `SEERD_PTR_STEP;
                        end
                    end
                end
                seerd_pkg::ST_TX: begin
                    if (fall) begin
                        if (cnt_r == `SEERD_LAST_BIT) begin
                            st_nxt  = seerd_pkg::ST_RACK;
                            cnt_nxt = '0;
                        end else begin
                            tx_nxt  = {tx_r[6:0], 1'b1};
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end
                end
                seerd_pkg::ST_RACK: begin
                    if (rise && sda_r[1]) begin
                        st_nxt = seerd_pkg::ST_WAIT;
                    end else if (fall) begin
                        st_nxt  = seerd_pkg::ST_TX;
                        tx_nxt  = f_valid ? f_data : 8'hff;
                        pop     = 1'b1;
                        ptr_nxt = ptr_r + `SEERD_PTR_STEP;
                    end
                end
                default: ;
            endcase
        end
        oe_nxt = (st_nxt == seerd_pkg::ST_ACK)
               || (st_nxt == seerd_pkg::ST_TX && !tx_nxt[7]);
        pf_nxt = flush ? ptr_nxt : (f_push_ok() ? pf_r + `SEERD_PTR_STEP : pf_r);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r    <= seerd_pkg::ST_IDLE;
            after_r <= seerd_pkg::ST_WADR;
            cnt_r   <= '0;
            sh_r    <= '0;
            tx_r    <= 8'hff;
            ptr_r   <= '0;
            pf_r    <= '0;
            oe_r    <= 1'b0;
            wrote_r <= 1'b0;
            busy_r  <= '0;
        end else begin
            st_r    <= st_nxt;
            after_r <= after_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            pf_r    <= pf_nxt;
            oe_r    <= oe_nxt;
            wrote_r <= wrote_nxt;
            busy_r  <= busy_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem_r[ptr_r] <= sh_r;
        end
    end

    // Prefetch runs ahead of the pointer; refilled on every pointer load
    seerd_fifo #(.W(8), .D(`SEERD_FIFO_DEPTH)) u_fifo (
        .clk       (sys_clk),
        .rst       (rst),
        .flush     (flush),
        .in_valid  (1'b1),
        .in_ready  (pf_ready),
        .in_data   (mem_r[pf_r]),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data)
    );

    assign sda_val = 1'b0;
    assign sda_oe  = oe_r;
    assign wr_busy = busy_r != '0;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ptr_after_pop: assert property (pop && !start && !stop
                                      |=> ptr_r == $past(ptr_r) + `SEERD_PTR_STEP)
        else $error("pointer did not advance after byte load");
    a_ptr_wraps_top: assert property (pop && ptr_r == 8'hff |=> ptr_r == 8'h00)
        else $error("pointer did not wrap to zero");
    a_tx_drives_bit: assert property (st_r == seerd_pkg::ST_TX |-> sda_oe == !tx_r[7])
        else $error("transmit bit not on data line");
    a_ack_pulls_low: assert property (st_r == seerd_pkg::ST_ACK |-> sda_oe)
        else $error("acknowledge not driven");
    a_nack_releases: assert property (st_r == seerd_pkg::ST_RACK && rise && sda_r[1] && !start
                                      && !stop |=> st_r == seerd_pkg::ST_WAIT && !sda_oe[*2])
        else $error("device kept sending after no acknowledge");
    a_type_mismatch: assert property (st_r == seerd_pkg::ST_DEVADR && fall && cnt_r == `SEERD_BITS
                                      && sh_r[7:4] != `SEERD_DEV_TYPE |=> !sda_oe)
        else $error("foreign address acknowledged");
    a_word_adr_load: assert property (st_r == seerd_pkg::ST_WADR && fall && cnt_r == `SEERD_BITS
                                      |=> ptr_r == $past(sh_r) && st_r == seerd_pkg::ST_ACK)
        else $error("word address not loaded");
    a_busy_no_ack: assert property (wr_busy && st_r == seerd_pkg::ST_DEVADR |-> ##1 !sda_oe)
        else $error("address acknowledged during internal write");
    a_start_aborts: assert property (start |=> st_r == seerd_pkg::ST_DEVADR && cnt_r == 4'h0)
        else $error("start did not restart address phase");
    a_stop_aborts: assert property (stop |=> st_r == seerd_pkg::ST_IDLE ##1 !sda_oe)
        else $error("stop did not return to idle");
    a_seq_next_byte: assert property (st_r == seerd_pkg::ST_RACK && fall && !start && !stop
                                      |=> st_r == seerd_pkg::ST_TX)
        else $error("acknowledged byte not followed");

    c_read_ack: cover property (st_r == seerd_pkg::ST_ACK && after_r == seerd_pkg::ST_TX);
    c_seq_read: cover property (st_r == seerd_pkg::ST_RACK ##1 st_r == seerd_pkg::ST_TX);
    c_ptr_wrap: cover property (pop && ptr_r == 8'hff);
    c_busy_poll: cover property (wr_busy && start);
endmodule

// >>> dv/seerd_master.sv
`timescale 1ns/1ps
module seerd_master (
    // Clock
    input  wire logic clk,
    // Open-drain bus; sda_pull high pulls data low
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data moves a cycle after the fall so both lines never move in one sample
    task automatic put_bit(input logic b, output logic s);
        tick(1);
        sda_pull = ~b;
        tick(3);
        scl = 1'b1;
        tick(3);
        s = sda;
        tick(1);
        scl = 1'b0;
    endtask
    // Start, repeated start or stop; clock stands high after a stop
    task automatic cond(input logic stop);
        tick(1);
        sda_pull = stop;
        tick(5);
        scl = 1'b1;
        tick(4);
        sda_pull = ~stop;
        tick(4);
        if (!stop) begin
            scl = 1'b0;
        end
    endtask
    // Ninth level: high to read an ack or to refuse more data
    task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(ninth, s);
        ack = ~s;
    endtask
endmodule

// >>> dv/seerd_top_tb.sv
`timescale 1ns/1ps
module seerd_top_tb;
    localparam int WR_CYC = 300;
    localparam int LIMIT  = 20000;
    logic       sys_clk, rst, scl, sda_pull, sda_w, sda_val, sda_oe, wr_busy;
    logic [7:0] exp_mem [256];
    int         num_errors, total_checks, cycles;
    // Pull-up wins unless a party pulls low
    assign sda_w = ((sda_oe && sda_val == 1'b0) || sda_pull) ? 1'b0 : 1'b1;
    seerd_top #(.WR_CYCLES(WR_CYC)) i_seerd_top (
        .sys_clk(sys_clk), .rst(rst), .scl_pin(scl), .sda_pin(sda_w),
        .sda_val(sda_val), .sda_oe(sda_oe), .wr_busy(wr_busy));
    seerd_master i_seerd_master (.clk(sys_clk), .scl(scl), .sda_pull(sda_pull), .sda(sda_w));
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic addr_phase(input logic [7:0] a, input logic exp_ack, input string what);
        logic [7:0] rx;
        logic       ack;
        i_seerd_master.cond(1'b0);
        i_seerd_master.xfer(a, 1'b1, rx, ack);
        chk(what, 8'(exp_ack), 8'(ack));
    endtask
    task automatic write_page(input logic [7:0] a, input logic [31:0] d);
        logic [7:0] rx;
        logic       ack;
        int         n = 0;
        addr_phase(8'h50, 1'b1, "wr addr ack");
        i_seerd_master.xfer(a, 1'b1, rx, ack);
        chk("word addr ack", 8'h01, 8'(ack));
        for (int k = 0; k < 4; k++) begin
            exp_mem[a + 8'(k)] = d[31-8*k -: 8];
            i_seerd_master.xfer(exp_mem[a + 8'(k)], 1'b1, rx, ack);
            chk("data ack", 8'h01, 8'(ack));
        end
        i_seerd_master.cond(1'b1);
        chk("busy", 8'h01, 8'(wr_busy));
        addr_phase(8'h50, 1'b0, "ack while busy");
        i_seerd_master.cond(1'b1);
        while (wr_busy !== 1'b0 && n < 400) begin
            i_seerd_master.tick(1);
            n++;
        end
        chk("busy end", 8'h00, 8'(wr_busy));
    endtask
    task automatic read_seq(input logic [7:0] first, input int cnt, input string what);
        logic [7:0] d;
        logic       ack;
        for (int k = 0; k < cnt; k++) begin
            i_seerd_master.xfer(8'hff, k == cnt - 1, d, ack);
            chk(what, exp_mem[first + 8'(k)], d);
        end
        for (int k = 0; k < 12; k++) begin
            i_seerd_master.tick(1);
            chk("oe after nack", 8'h00, 8'(sda_oe));
        end
        i_seerd_master.cond(1'b1);
    endtask
    // Eight bytes across the top of memory wrap the pointer from 255 to 0 while the prefetch buffer keeps refilling
    task automatic long_read();
        logic [7:0] rx;
        logic       ack;
        addr_phase(8'h50, 1'b1, "long dummy ack");
        i_seerd_master.xfer(8'hfc, 1'b1, rx, ack);
        chk("long word ack", 8'h01, 8'(ack));
        addr_phase(8'h51, 1'b1, "long restart ack");
        read_seq(8'hfc, 8, "long read");
    endtask
    initial begin
        logic [7:0] rx;
        logic       ack;
        rst = 1'b1;
        i_seerd_master.tick(4);
        rst = 1'b0;
        i_seerd_master.tick(4);
        write_page(8'h00, 32'h11223344);
        write_page(8'hfc, 32'ha55ac33c);
        addr_phase(8'h51, 1'b1, "rd addr ack");
        // Page write rolled the pointer back to the page start
        read_seq(8'hfc, 1, "current read");
        addr_phase(8'h50, 1'b1, "dummy wr ack");
        i_seerd_master.xfer(8'hfe, 1'b1, rx, ack);
        chk("dummy word ack", 8'h01, 8'(ack));
        addr_phase(8'h51, 1'b1, "restart ack");
        read_seq(8'hfe, 4, "seq read");
        addr_phase(8'h71, 1'b0, "foreign ack");
        i_seerd_master.cond(1'b1);
        addr_phase(8'h5f, 1'b1, "reserved ack");
        read_seq(8'h02, 1, "next read");
        addr_phase(8'h50, 1'b1, "abort wr ack");
        for (int k = 0; k < 3; k++) begin
            i_seerd_master.put_bit(1'b1, ack);
        end
        addr_phase(8'h51, 1'b1, "ack after abort");
        read_seq(8'h03, 1, "read after abort");
        long_read();
        give_verdict();
    end
endmodule
